// ==== hdl/mpwm_pkg.sv ====
// Constants, types and the work list of the four-channel multiplexed PWM block.
// Assumes a single 40 MHz core clock; all inputs synchronous to it.
//
// Function
// [RQ1] Four PWM pins, 254 duty levels each
// [RQ2] Tick every 3.9 us from 8-bit timer
// [RQ3] Period about 1 ms of timer ticks
// [RQ4] Load selected table set into duty counters
// [RQ5] Each tick decrements every duty counter
// [RQ6] Counter zero clears pending bit, pin next
// [RQ7] Period end reloads counters and pending data
// [RQ8] All four channels processed in parallel
// [RQ9] Drive prepared data first, then compute next
// [RQ10] Switch press advances to next table set
// [RQ11] Initial bit zero for 0%, else one
// [RQ12] Ignore the first tick after timer start
// [RQ13] First valid tick drives initial values
// [RQ14] Period counter zero on 254th valid tick
// [RQ15] 100% duty stays high whole period
// [RQ16] Next period data ready before boundary
// [RQ17] Press at boundary applies period after next
// [RQ18] Debounce switch, one advance per press
// [RQ19] Table entries in 5% steps of 254
// [RQ20] Reset: outputs low, set zero, idle
package mpwm_pkg;

    localparam int NUM_CH = 4;
    localparam int CORE_CLK_HZ = 40000000;
    localparam int TICK_NS = 3900;
    // Longest time, so round down; 156 cycles at 40 MHz
    localparam int TICK_CYCLES = (TICK_NS * (CORE_CLK_HZ / 1000000)) / 1000;
    localparam logic [7:0] TICK_LOAD = 8'(TICK_CYCLES - 1);
    localparam logic [7:0] SCALE = 8'hFE;
    localparam logic [7:0] PERIOD_LOAD = 8'hFE;
    localparam int NUM_SETS = 4;
    localparam logic [1:0] SET_RESET = 2'h0;
    // Debounce: stable switch level for this many ticks (about 1 ms)
    localparam logic [7:0] DEBOUNCE_TICKS = 8'hFF;
    localparam logic [NUM_CH-1:0] OUT_RESET = 4'h0;

    typedef logic [7:0] mpwm_duty_t;
    typedef struct packed {
        mpwm_duty_t ch3;
        mpwm_duty_t ch2;
        mpwm_duty_t ch1;
        mpwm_duty_t ch0;
    } mpwm_set_t;

    // Duty table in 5% steps: (SCALE*pct+50)/100
    localparam mpwm_set_t DUTY_TABLE [NUM_SETS] = '{
        '{ch3: 8'h00, ch2: 8'h40, ch1: 8'h7F, ch0: 8'hFE},
        '{ch3: 8'h19, ch2: 8'h66, ch1: 8'hBF, ch0: 8'hE5},
        '{ch3: 8'h7F, ch2: 8'h00, ch1: 8'hFE, ch0: 8'h33},
        '{ch3: 8'hFE, ch2: 8'hBF, ch1: 8'h0D, ch0: 8'h00}
    };

endpackage

// ==== hdl/mpwm_top.sv ====
// Four-channel multiplexed PWM generator with switch-selected duty sets.
// Assumes switch input is a clean-sampled level, high while pressed.
`timescale 1ns/1ps
`default_nettype none

module mpwm_top
    import mpwm_pkg::*;
(
    input wire logic core_clk, // 40 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic timerStart, // Level: timer runs while high
    input wire logic switchInputPin, // Duty select switch, high pressed
    output logic [NUM_CH-1:0] pwmOutputPins, // PWM outputs
    output logic [1:0] dutySetSel, // Current table set
    output logic periodStrobe // One-cycle pulse at period end
);

    // ------------------------------------------------------------
    // Tick timer
    // ------------------------------------------------------------
    logic [7:0] tickCnt_reg;
    logic tickInterrupt_reg;
    logic running_reg;
    logic armed_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCnt_reg <= 8'h00;
            tickInterrupt_reg <= 1'b0;
        end else if (!timerStart) begin
            tickCnt_reg <= TICK_LOAD;
            tickInterrupt_reg <= 1'b0;
        end else if (tickCnt_reg == 8'h00) begin
            tickCnt_reg <= TICK_LOAD; // RQ2
            tickInterrupt_reg <= 1'b1;
        end else begin
            tickCnt_reg <= tickCnt_reg - 8'h01;
            tickInterrupt_reg <= 1'b0;
        end
    end

    // First tick after start only arms the engine
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
            running_reg <= 1'b0;
        end else if (!timerStart) begin
            armed_reg <= 1'b0; // RQ20
            running_reg <= 1'b0;
        end else if (tickInterrupt_reg) begin
            armed_reg <= 1'b1; // RQ12
            running_reg <= armed_reg;
        end
    end

    logic validTick;
    assign validTick = tickInterrupt_reg && armed_reg;

    // ------------------------------------------------------------
    // Switch debounce
    // ------------------------------------------------------------
    logic swStable_reg;
    logic [7:0] swCnt_reg;
    logic pressPending_reg;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            swStable_reg <= 1'b0;
            swCnt_reg <= 8'h00;
        end else if (switchInputPin == swStable_reg) begin
            swCnt_reg <= 8'h00;
        end else if (tickInterrupt_reg) begin
            // Level must hold for a full count of ticks to count as a change
            if (swCnt_reg == DEBOUNCE_TICKS) begin
                swStable_reg <= switchInputPin; // RQ18
                swCnt_reg <= 8'h00;
            end else begin
                swCnt_reg <= swCnt_reg + 8'h01;
            end
        end
    end

    logic pressEvent;
    assign pressEvent = tickInterrupt_reg && (swCnt_reg == DEBOUNCE_TICKS)
        && switchInputPin && !swStable_reg;

    // ------------------------------------------------------------
    // Set selection
    // ------------------------------------------------------------
    logic [7:0] periodCnt_reg;
    logic boundary;
    logic [1:0] setSel_reg;
    logic [1:0] loadSel_reg;

    assign boundary = validTick && running_reg && (periodCnt_reg == 8'h01);

    // Press is held until the boundary; set wins over clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pressPending_reg <= 1'b0;
        end else if (pressEvent) begin
            pressPending_reg <= 1'b1;
        end else if (boundary) begin
            pressPending_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            setSel_reg <= SET_RESET; // RQ20
        end else if (boundary && pressPending_reg) begin
            setSel_reg <= setSel_reg + 2'h1; // RQ10
        end
    end

    // Loaded set lags one boundary behind the selection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            loadSel_reg <= SET_RESET;
        end else if (!timerStart) begin
            loadSel_reg <= setSel_reg;
        end else if (boundary) begin
            loadSel_reg <= setSel_reg; // RQ17
        end
    end

    function automatic mpwm_duty_t dutyOf(input logic [1:0] sel, input int ch);
        mpwm_set_t s;
        s = DUTY_TABLE[sel]; // RQ19
        case (ch)
            0: dutyOf = s.ch0;
            1: dutyOf = s.ch1;
            2: dutyOf = s.ch2;
            default: dutyOf = s.ch3;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            periodCnt_reg <= PERIOD_LOAD;
        end else if (!running_reg && !validTick) begin
            periodCnt_reg <= PERIOD_LOAD;
        end else if (validTick) begin
            if (periodCnt_reg == 8'h01) begin
                periodCnt_reg <= PERIOD_LOAD; // RQ14 RQ3
            end else begin
                periodCnt_reg <= periodCnt_reg - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-channel duty counters and pending data
    // ------------------------------------------------------------
    // One flip-flop per channel block, gathered on a net so no variable has two writers
    wire logic [NUM_CH-1:0] pendingBits;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gCh // RQ8
            mpwm_duty_t dutyCnt_reg;
            mpwm_duty_t loadVal;
            logic initBit;
            logic pend_reg;
            assign loadVal = dutyOf(boundary ? setSel_reg : loadSel_reg, g); // RQ4
            assign initBit = (loadVal != 8'h00); // RQ11
            assign pendingBits[g] = pend_reg;

            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    dutyCnt_reg <= 8'h00;
                    pend_reg <= 1'b0;
                end else if (!running_reg && !validTick) begin
                    dutyCnt_reg <= loadVal;
                    pend_reg <= initBit;
                end else if (boundary) begin
                    dutyCnt_reg <= loadVal; // RQ7 RQ16
                    pend_reg <= initBit;
                end else if (validTick) begin
                    // SCALE duty never reaches zero inside a period
                    if (dutyCnt_reg == 8'h01) begin
                        pend_reg <= 1'b0; // RQ6 RQ15
                    end
                    if (dutyCnt_reg != 8'h00) begin
                        dutyCnt_reg <= dutyCnt_reg - 8'h01; // RQ5
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwmOutputPins <= OUT_RESET; // RQ20
        end else if (!timerStart) begin
            pwmOutputPins <= OUT_RESET;
        end else if (validTick) begin
            pwmOutputPins <= pendingBits; // RQ9 RQ13 RQ1
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dutySetSel <= SET_RESET;
            periodStrobe <= 1'b0;
        end else begin
            dutySetSel <= loadSel_reg;
            periodStrobe <= boundary;
        end
    end

endmodule

`default_nettype wire

// ==== verif/mpwm_checker.sv ====
// Port assertions for mpwm_top, bound in below.
// Assumes one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mpwm_checker
    import mpwm_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic timerStart, // Timer run
    input wire logic switchInputPin, // Switch
    input wire logic [NUM_CH-1:0] pwmOutputPins, // Outputs
    input wire logic [1:0] dutySetSel, // Set
    input wire logic periodStrobe // Period end
);
    function automatic logic [3:0] initOf(input logic [1:0] sel);
        initOf = {DUTY_TABLE[sel].ch3 != 8'h00, DUTY_TABLE[sel].ch2 != 8'h00,
            DUTY_TABLE[sel].ch1 != 8'h00, DUTY_TABLE[sel].ch0 != 8'h00};
    endfunction
    logic [3:0] pwmPrev;
    logic [15:0] sinceEdge;
    logic [15:0] sinceStrobe;
    logic [9:0] startCnt;
    // Zero means not yet seen; saturate so a stall cannot wrap
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwmPrev <= 4'h0;
            sinceEdge <= 16'h0000;
            sinceStrobe <= 16'h0000;
            startCnt <= 10'h000;
        end else if (!timerStart) begin
            // Stop drops the pins off the tick grid; history restarts with the timer
            pwmPrev <= pwmOutputPins;
            sinceEdge <= 16'h0000;
            sinceStrobe <= 16'h0000;
            startCnt <= 10'h000;
        end else begin
            pwmPrev <= pwmOutputPins;
            sinceEdge <= (pwmOutputPins != pwmPrev) ? 16'h0001 :
                sinceEdge + 16'(sinceEdge != 16'h0000 && sinceEdge != 16'hFFFF);
            sinceStrobe <= periodStrobe ? 16'h0001 :
                sinceStrobe + 16'(sinceStrobe != 16'h0000 && sinceStrobe != 16'hFFFF);
            startCnt <= startCnt + 10'(timerStart && startCnt != 10'h3FF);
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    armed_quiet_a: assert property (startCnt < 10'h136 |-> pwmOutputPins == OUT_RESET)
        else $error("output before second tick");
    init_bits_a: assert property (startCnt == 10'h140 |-> pwmOutputPins == initOf(dutySetSel))
        else $error("wrong initial bits");
    tick_spacing_a: assert property (pwmOutputPins != pwmPrev && sinceEdge != 16'h0000
        |-> sinceEdge % TICK_CYCLES == 0) else $error("output off tick grid");
    period_length_a: assert property (periodStrobe && sinceStrobe != 16'h0000
        |-> sinceStrobe == 16'(TICK_CYCLES * 254)) else $error("period length wrong");
    strobe_pulse_a: assert property (periodStrobe |=> !periodStrobe)
        else $error("strobe too long");
    rise_at_reload_a: assert property ((|(pwmOutputPins & ~pwmPrev)) && startCnt > 10'h14A
        |-> sinceStrobe == 16'(TICK_CYCLES)) else $error("mid rise");
    set_step_a: assert property (dutySetSel != $past(dutySetSel)
        |-> dutySetSel == $past(dutySetSel) + 2'h1) else $error("set skipped");
    set_boundary_a: assert property ($past(timerStart, 2) && dutySetSel != $past(dutySetSel)
        |-> (periodStrobe || $past(periodStrobe)) or ##1 periodStrobe) else $error("set mid period");
endmodule
bind mpwm_top mpwm_checker mpwm_checker_inst (.core_clk(core_clk), .reset_n(reset_n),
    .timerStart(timerStart), .switchInputPin(switchInputPin), .pwmOutputPins(pwmOutputPins),
    .dutySetSel(dutySetSel), .periodStrobe(periodStrobe));
`default_nettype wire

// ==== verif/mpwm_switch_model.sv ====
// Push switch model with contact chatter on every change.
// Assumes pressCmd changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module mpwm_switch_model (
    input wire logic core_clk, // Clock
    input wire logic pressCmd, // Hold switch down
    output logic switchInputPin // Switch level
);
    logic lastCmd = 1'b0;
    logic [7:0] chatter = 8'h00;
    initial switchInputPin = 1'b0;
    // Chatter lasts far less than one debounce window
    always @(posedge core_clk) begin
        #1;
        if (pressCmd != lastCmd) begin
            lastCmd = pressCmd;
            chatter = 8'hC0;
        end
        if (chatter != 8'h00) begin
            chatter = chatter - 8'h01;
            if (chatter[4:0] == 5'h00)
                switchInputPin = ~switchInputPin;
        end else
            switchInputPin = lastCmd;
    end
endmodule
`default_nettype wire

// ==== verif/mpwm_tb_top.sv ====
// Bench for mpwm_top: reset, arming, two periods, one press.
// Assumes the switch model and bound checker compile first.
`timescale 1ns/1ps
`default_nettype none
module mpwm_tb_top;
    import mpwm_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic timerStart = 1'b0;
    logic pressCmd = 1'b0;
    logic switchInputPin;
    logic [3:0] pwmOutputPins;
    logic [1:0] dutySetSel;
    logic periodStrobe;
    int bad_count = 0;
    int n_compared = 0;
    always #12.5 core_clk = ~core_clk;
    mpwm_top mpwm_top_inst (.core_clk(core_clk), .reset_n(reset_n), .timerStart(timerStart),
        .switchInputPin(switchInputPin), .pwmOutputPins(pwmOutputPins),
        .dutySetSel(dutySetSel), .periodStrobe(periodStrobe));
    mpwm_switch_model mpwm_switch_model_inst (.core_clk(core_clk), .pressCmd(pressCmd),
        .switchInputPin(switchInputPin));
    task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Pin i high for the first D_i valid ticks of a period
    function automatic logic [3:0] expect_pins(input int sel, input int k);
        mpwm_set_t s;
        s = DUTY_TABLE[sel];
        return {k <= s.ch3, k <= s.ch2, k <= s.ch1, k <= s.ch0};
    endfunction
    task automatic test_reset;
        step(2);
        cmp("pins in reset", 4'h0, pwmOutputPins);
        cmp("set in reset", 4'h0, {2'h0, dutySetSel});
        step(14);
        reset_n = 1'b1;
        step(200);
        cmp("pins idle", 4'h0, pwmOutputPins);
        $display("reset test done");
    endtask
    // Samples mid-way between ticks, clear of update edges
    task automatic test_arm;
        timerStart = 1'b1;
        step(1 + TICK_CYCLES + 78);
        cmp("pins after first tick", 4'h0, pwmOutputPins);
        step(TICK_CYCLES);
        $display("arm test done");
    endtask
    task automatic test_period(input int p);
        for (int k = 1; k <= 254; k++) begin
            if (p == 1 && k == 10)
                pressCmd = 1'b1;
            if (p == 2 && k == 100)
                pressCmd = 1'b0;
            cmp($sformatf("pins p%0d k%0d", p, k), expect_pins(0, k), pwmOutputPins);
            step(TICK_CYCLES);
        end
        $display("period %0d test done", p);
    endtask
    // New set only shows two boundaries on; a stop and restart reaches it sooner
    task automatic test_restart;
        cmp("pins after press", expect_pins(0, 1), pwmOutputPins);
        cmp("set after press", 4'h0, {2'h0, dutySetSel});
        timerStart = 1'b0;
        step(4);
        cmp("set after stop", 4'h1, {2'h0, dutySetSel});
        cmp("pins after stop", 4'h0, pwmOutputPins);
        timerStart = 1'b1;
        step(1 + TICK_CYCLES + 78);
        cmp("pins rearmed", 4'h0, pwmOutputPins);
        step(TICK_CYCLES);
        cmp("pins new set", expect_pins(1, 1), pwmOutputPins);
        $display("restart test done");
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        test_reset();
        test_arm();
        test_period(1);
        test_period(2);
        test_restart();
        close_out();
    end
endmodule
`default_nettype wire
